// ---- logic/fre_consts.svh ----
// Constants for the flash area range and valid-area protection block.
// Included by the package and the design; definitions only.
`ifndef FRE_CONSTS_SVH
`define FRE_CONSTS_SVH

`define FRE_ADDR_W          8
`define FRE_OFF_END_ADDR    8'h34
`define FRE_OFF_PROTECT     8'h40
`define FRE_OFF_START_ADDR  8'h30
`define FRE_OFF_CONTROL     8'h38
`define FRE_OFF_STATUS      8'h44
`define FRE_OFF_IRQ_STATUS  8'h48
`define FRE_OFF_IRQ_MASK    8'h4C
`define FRE_END_RESET       32'h00000000
`define FRE_PROT_RESET      1'b1
`define FRE_PROT_KEY        8'hFE
`define FRE_CMP_MSB         20
`define FRE_END_RO_MASK     32'hFFFFFFFC
`define FRE_CTL_DIR_BIT     0
`define FRE_CTL_INIT_BIT    1
`define FRE_DATA_AREA_LSB   16
`define FRE_IRQ_W           3
`define FRE_RESP_OKAY       2'b00
`define FRE_RESP_SLVERR     2'b10

`endif

// ---- logic/fre_pkg.sv ----
// Types shared by the flash area range and protection block.
// Constants sit in fre_consts.svh.
`include "fre_consts.svh"
package fre_pkg;
  typedef enum logic [3:0] {
    FRE_CMD_NONE       = 4'b0001,
    FRE_CMD_AREA_ERASE = 4'b0010,
    FRE_CMD_BLANK      = 4'b0100,
    FRE_CMD_CODE_WRITE = 4'b1000
  } fre_cmd_e;
  typedef enum logic [2:0] {
    FRE_ST_READY = 3'b001,
    FRE_ST_BUSY  = 3'b010,
    FRE_ST_LOCK  = 3'b100
  } fre_state_e;
endpackage

// ---- logic/fre_range_protect.sv ----
// Area end-address register, code-flash valid-area protection register
// and the range consistency check of the flash command interface.
// Assumes an AXI4-Lite master on clk; the sequencer drives cmd_* and done.
//
// Contract
// [R1] Area erasure with start above end is an error and locks commands.
// [R2] Incrementing blank check needs start not above end.
// [R3] Decrementing blank check needs start not below end.
// [R4] Inconsistent direction, start and end on blank check locks commands.
// [R5] Range crossing a data-area boundary is an error and locks commands.
// [R6] Sequencer-init bit set to 1 resets both registers.
// [R7] End-address bits 31..21 ignored; bits 20..0 compared.
// [R8] End address is a 32-bit word, resets to zero, bits 1..0 read-only.
// [R9] Writes to end or protect ignored while busy; allowed in lock.
// [R10] Protection register is 16-bit, resets to 0001, protection on.
// [R11] Key field 15..8 is write-only and reads as zero.
// [R12] Protection bit changes only when the same write carries key FE.
// [R13] Protection on in double map refuses code writes to valid area.
// [R14] Protection bits 7..1 read as zero.
// [R15] Without a user area the protection bit has no effect.
// [R16] Start-address bits 31..21 ignored for data-flash commands.
// [R17] A write with wrong key keeps the protection bit.
//
// Register map, byte offsets on the AXI4-Lite port
//   0x30 start address, full word, readable
//   0x34 end address, bits 1..0 fixed at zero
//   0x38 control: bit 0 blank-check direction, bit 1 sequencer init
//   0x3C unmapped, answered with SLVERR
//   0x40 valid-area protect, low halfword, key in bits 15..8
//   0x44 status: bit 0 ready, bit 2 command lock
//   0x48 event status, cleared by a read
//   0x4C event mask, same layout as the status
//
// Event bits: 0 lock entered, 1 protection refusal, 2 command done.
// Writes to unknown offsets still answer, with SLVERR, so a stray
// pointer never hangs the bus.
// Data-area size is taken as 64 KiB: a range whose bits 20..16
// differ between start and end crosses an area boundary.
`include "fre_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module fre_range_protect #(
  parameter bit HAS_USER_AREA = 1'b1
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    clk_en,
  // AXI4-Lite write address and data
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // Sequencer side
  input  wire logic                    cmd_valid,
  input  wire fre_pkg::fre_cmd_e       cmd_kind,
  input  wire logic                    cmd_valid_area,
  input  wire logic                    double_map,
  input  wire logic                    cmd_done,
  output logic                         cmd_accept,
  output logic                         cmd_refuse,
  output logic                         command_lock,
  output logic                         sequencer_ready_flag,
  output logic [31:0]                  area_end_address,
  output logic                         valid_area_protect,
  // Interrupt
  output logic                         irq
);
  import fre_pkg::*;

  logic [31:0]               command_end_address;
  logic                      code_valid_area_protect;
  logic [31:0]               area_start_address;
  logic                      blank_check_direction;
  fre_state_e                state;
  logic [`FRE_IRQ_W-1:0]     irq_status;
  logic [`FRE_IRQ_W-1:0]     irq_mask;

  // Write capture, held until both halves are in
  logic                      aw_held;
  logic                      w_held;
  logic [7:0]                aw_addr;
  logic [31:0]               w_data;
  logic [3:0]                w_strb;

  // Decode and sequencer control
  logic                      wr_go;
  logic                      rd_go;
  logic                      init_pulse;
  logic                      regs_open;
  logic                      range_err;
  logic                      prot_refuse;
  logic                      cmd_take;
  logic [`FRE_IRQ_W-1:0]     irq_event;
  logic [31:0]               next_rdata;
  logic                      next_rerr;
  logic                      wr_known;
  logic                      ev_lock;
  logic                      ev_refuse;
  logic                      ev_done;

  // Compared address: only the low 21 bits take part
  function automatic logic [`FRE_CMP_MSB:0] cmp_addr(input logic [31:0] a);
    cmp_addr = a[`FRE_CMP_MSB:0];
  endfunction

  function automatic logic [`FRE_CMP_MSB-`FRE_DATA_AREA_LSB:0] area_of(input logic [31:0] a);
    area_of = a[`FRE_CMP_MSB:`FRE_DATA_AREA_LSB];
  endfunction

  // Write side: address and data are taken in either order, held until both
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_go         = aw_held && w_held && !s_axi_bvalid && clk_en;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go         = s_axi_arvalid && s_axi_arready && clk_en;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else if (clk_en) begin
      // Both halves may arrive in one cycle; each ready drops once its half is held
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  always_comb begin
    case (aw_addr)
      `FRE_OFF_END_ADDR, `FRE_OFF_PROTECT, `FRE_OFF_START_ADDR, `FRE_OFF_CONTROL,
      `FRE_OFF_STATUS, `FRE_OFF_IRQ_STATUS, `FRE_OFF_IRQ_MASK: wr_known = 1'b1;
      default: wr_known = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `FRE_RESP_OKAY;
    end else if (clk_en) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? `FRE_RESP_OKAY : `FRE_RESP_SLVERR;
      end else if (s_axi_bready) begin
        // No new write is taken while a response is still pending
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Init is a pulse; the control register does not store it
  assign init_pulse = wr_go && aw_addr == `FRE_OFF_CONTROL && w_strb[0] && w_data[`FRE_CTL_INIT_BIT];

  // Busy blocks the writes; the lock state reopens them for recovery
  assign regs_open  = state != FRE_ST_BUSY; // see [R9]

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      command_end_address <= `FRE_END_RESET; // see [R8]
    end else if (clk_en) begin
      if (init_pulse) begin
        command_end_address <= `FRE_END_RESET; // see [R6]
      end else if (wr_go && aw_addr == `FRE_OFF_END_ADDR && w_strb == 4'hF && regs_open) begin
        command_end_address <= s_axi_wdata_mask(w_data); // see [R8]
      end
    end
  end

  function automatic logic [31:0] s_axi_wdata_mask(input logic [31:0] d);
    s_axi_wdata_mask = d & `FRE_END_RO_MASK;
  endfunction

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      code_valid_area_protect <= `FRE_PROT_RESET; // see [R10]
    end else if (clk_en) begin
      if (init_pulse) begin
        code_valid_area_protect <= `FRE_PROT_RESET; // see [R6]
      end else if (wr_go && aw_addr == `FRE_OFF_PROTECT && w_strb[1:0] == 2'h3 && regs_open
                   && w_data[15:8] == `FRE_PROT_KEY) begin
        // Other keys leave the bit alone
        code_valid_area_protect <= w_data[0]; // see [R12] see [R17]
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      area_start_address    <= 32'h00000000;
      blank_check_direction <= 1'b0;
      irq_mask              <= '0;
    end else if (clk_en && wr_go) begin
      if (aw_addr == `FRE_OFF_START_ADDR && w_strb == 4'hF && regs_open) begin
        area_start_address <= w_data;
      end
      if (aw_addr == `FRE_OFF_CONTROL && w_strb[0] && regs_open) begin
        blank_check_direction <= w_data[`FRE_CTL_DIR_BIT];
      end
      if (aw_addr == `FRE_OFF_IRQ_MASK && w_strb[0]) begin
        irq_mask <= w_data[`FRE_IRQ_W-1:0];
      end
    end
  end

  // Range check uses the low 21 bits of both addresses only
  always_comb begin
    range_err = 1'b0;
    case (cmd_kind)
      FRE_CMD_AREA_ERASE: begin
        range_err = cmp_addr(area_start_address) > cmp_addr(command_end_address); // see [R1] see [R7] see [R16]
      end
      FRE_CMD_BLANK: begin
        if (blank_check_direction) begin
          range_err = cmp_addr(area_start_address) < cmp_addr(command_end_address); // see [R3] see [R4]
        end else begin
          range_err = cmp_addr(area_start_address) > cmp_addr(command_end_address); // see [R2] see [R4]
        end
      end
      default: range_err = 1'b0;
    endcase
    if ((cmd_kind == FRE_CMD_AREA_ERASE || cmd_kind == FRE_CMD_BLANK)
        && area_of(area_start_address) != area_of(command_end_address)) begin
      range_err = 1'b1; // see [R5]
    end
  end

  // No user area means the bit never refuses
  assign prot_refuse = HAS_USER_AREA && code_valid_area_protect && double_map
                       && cmd_valid_area && cmd_kind == FRE_CMD_CODE_WRITE; // see [R13] see [R15]
  assign cmd_take    = cmd_valid && clk_en && state == FRE_ST_READY;

  // Sequencer state: ready, busy with a command, or locked after a range error.
  // A refusal by protection is not an error, so the sequencer stays ready.

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state      <= FRE_ST_READY;
      cmd_accept <= 1'b0;
      cmd_refuse <= 1'b0;
    end else if (clk_en) begin
      cmd_accept <= 1'b0;
      cmd_refuse <= 1'b0;
      case (state)
        FRE_ST_READY: begin
          if (cmd_take) begin
            if (range_err) begin
              state      <= FRE_ST_LOCK; // see [R1] see [R4] see [R5]
              cmd_refuse <= 1'b1;
            end else if (prot_refuse) begin
              cmd_refuse <= 1'b1; // see [R13]
            end else begin
              state      <= FRE_ST_BUSY;
              cmd_accept <= 1'b1;
            end
          end
        end
        FRE_ST_BUSY: begin
          // Start, end, protect and direction writes stay closed until the sequencer reports done
          if (cmd_done) begin
            state <= FRE_ST_READY;
          end
        end
        FRE_ST_LOCK: begin
          // Software leaves the lock through the sequencer-init bit
          if (init_pulse) begin
            state <= FRE_ST_READY;
          end
        end
        default: state <= FRE_ST_READY;
      endcase
    end
  end

  assign command_lock         = state == FRE_ST_LOCK;
  assign sequencer_ready_flag = state != FRE_ST_BUSY;
  assign area_end_address     = command_end_address;
  assign valid_area_protect   = code_valid_area_protect;

  // Events: lock entered, command refused by protection, command finished
  assign ev_lock   = cmd_take && range_err;
  assign ev_refuse = cmd_take && !range_err && prot_refuse;
  assign ev_done   = cmd_done && state == FRE_ST_BUSY;
  assign irq_event = {ev_done, ev_refuse, ev_lock};


  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_status <= '0;
    end else if (clk_en) begin
      // A new event outranks the clear-on-read in the same cycle
      if (rd_go && s_axi_araddr == `FRE_OFF_IRQ_STATUS) begin
        irq_status <= irq_event;
      end else begin
        irq_status <= irq_status | irq_event;
      end
    end
  end

  // Level output; masking hides an event but does not clear it
  assign irq = |(irq_status & irq_mask);

  // Unmapped reads return zero with SLVERR

  always_comb begin
    next_rdata = 32'h00000000;
    next_rerr  = 1'b0;
    case (s_axi_araddr)
      `FRE_OFF_END_ADDR:   next_rdata = command_end_address; // see [R8]
      // Key reads zero and bits 7..1 read zero
      `FRE_OFF_PROTECT:    next_rdata = {31'h00000000, code_valid_area_protect}; // see [R11] see [R14]
      `FRE_OFF_START_ADDR: next_rdata = area_start_address;
      `FRE_OFF_CONTROL:    next_rdata = {31'h00000000, blank_check_direction};
      `FRE_OFF_STATUS:     next_rdata = {29'h00000000, command_lock, 1'b0, sequencer_ready_flag};
      `FRE_OFF_IRQ_STATUS: next_rdata = {29'h00000000, irq_status};
      `FRE_OFF_IRQ_MASK:   next_rdata = {29'h00000000, irq_mask};
      default:             next_rerr  = 1'b1;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `FRE_RESP_OKAY;
    end else if (clk_en) begin
      // Data is registered in the take cycle and stands until rready
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= next_rerr ? `FRE_RESP_SLVERR : `FRE_RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/fre_range_protect_monitor.sv ----
// Checker for the flash area range and valid-area protection block.
// Sees only the top module's ports; bound to every instance at the foot.
`include "fre_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module fre_range_protect_monitor #(
  parameter bit HAS_USER_AREA = 1'b1
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              clk_en,
  // Register bus
  input wire logic [7:0]        s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  // Sequencer side
  input wire logic              cmd_valid,
  input wire fre_pkg::fre_cmd_e cmd_kind,
  input wire logic              cmd_valid_area,
  input wire logic              double_map,
  input wire logic              cmd_accept,
  input wire logic              cmd_refuse,
  input wire logic              command_lock,
  input wire logic              sequencer_ready_flag,
  input wire logic [31:0]       area_end_address,
  input wire logic              valid_area_protect
);
  import fre_pkg::*;
  logic [7:0]  wa;
  logic [31:0] wd;
  logic [3:0]  ws;
  logic        bv_q;
  logic        wr_done;
  logic        take;
  logic        guard;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk) if (clk_en && s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
  always_ff @(posedge clk) if (clk_en && s_axi_wvalid && s_axi_wready) {wd, ws} <= {s_axi_wdata, s_axi_wstrb};
  // Hand-made edge detect: the register write lands on the edge that raises the response
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) bv_q <= 1'b0;
    else bv_q <= s_axi_bvalid;
  end
  assign wr_done = s_axi_bvalid && !bv_q;
  assign take = cmd_valid && clk_en && sequencer_ready_flag && !command_lock;
  assign guard = HAS_USER_AREA && double_map && cmd_valid_area;
  a_end_low_zero: assert property (area_end_address[1:0] == 2'h0)
    else $error("end address low bits not zero");
  a_end_write_lands: assert property (wr_done && wa == `FRE_OFF_END_ADDR && ws == 4'hF && $past(sequencer_ready_flag)
    |-> area_end_address == (wd & `FRE_END_RO_MASK)) else $error("end address write lost");
  a_init_resets: assert property (wr_done && wa == `FRE_OFF_CONTROL && ws[0] && wd[`FRE_CTL_INIT_BIT]
    |-> area_end_address == `FRE_END_RESET && valid_area_protect == `FRE_PROT_RESET) else $error("init missed");
  a_prot_key_write: assert property (wr_done && wa == `FRE_OFF_PROTECT && ws[1:0] == 2'h3
    && $past(sequencer_ready_flag) && wd[15:8] == `FRE_PROT_KEY |-> valid_area_protect == wd[0])
    else $error("keyed protect write lost");
  a_prot_bad_key: assert property (wr_done && wa == `FRE_OFF_PROTECT && wd[15:8] != `FRE_PROT_KEY
    |-> $stable(valid_area_protect)) else $error("protect changed without key");
  a_busy_end_hold: assert property (!sequencer_ready_flag && !$past(sequencer_ready_flag)
    |-> $stable(area_end_address) || area_end_address == `FRE_END_RESET) else $error("end written while busy");
  a_busy_prot_hold: assert property (!sequencer_ready_flag && !$past(sequencer_ready_flag)
    |-> $stable(valid_area_protect) || valid_area_protect) else $error("protect written while busy");
  a_cmd_answers: assert property (take |=> cmd_accept ^ cmd_refuse)
    else $error("command not answered");
  a_lock_on_range: assert property ($rose(command_lock) |-> cmd_refuse && $past(cmd_kind) != FRE_CMD_CODE_WRITE)
    else $error("lock without range refusal");
  a_prot_refuses: assert property (take && cmd_kind == FRE_CMD_CODE_WRITE && guard && valid_area_protect
    |=> cmd_refuse && !command_lock) else $error("protected write not refused");
  a_prot_allows: assert property (take && cmd_kind == FRE_CMD_CODE_WRITE && !(guard && valid_area_protect)
    |=> cmd_accept) else $error("unprotected write refused");
endmodule
bind fre_range_protect fre_range_protect_monitor #(.HAS_USER_AREA(HAS_USER_AREA)) u_monitor (
  .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
  .cmd_valid_area(cmd_valid_area), .double_map(double_map), .cmd_accept(cmd_accept), .cmd_refuse(cmd_refuse),
  .command_lock(command_lock), .sequencer_ready_flag(sequencer_ready_flag), .area_end_address(area_end_address),
  .valid_area_protect(valid_area_protect)
);
`default_nettype wire

// ---- tb/fre_range_protect_tb.sv ----
// Self-checking bench for the flash area range and protection block.
// Drives the register bus and sequencer ports itself; response readies are held high.
`include "fre_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module fre_range_protect_tb;
  import fre_pkg::*;
  logic        clk = 1'b0, sys_rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic        cmd_valid = 1'b0, cva = 1'b0, dmap = 1'b0, cmd_done = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, key;
  logic [31:0] wdata = 32'h0, rdata, d, s, e, end_q;
  logic [3:0]  wstrb = 4'h0;
  logic [1:0]  bresp, rresp, r;
  logic [2:0]  ans;
  logic        awready, wready, bvalid, arready, rvalid, acc, rf, lock, rdy, prot, irq, dir, b;
  fre_cmd_e    kind = FRE_CMD_NONE;
  fre_cmd_e    k;
  int          err_count = 0, comparisons = 0;

  always #20 clk = ~clk;

  fre_range_protect dut (
    .clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .cmd_valid(cmd_valid), .cmd_kind(kind), .cmd_valid_area(cva), .double_map(dmap), .cmd_done(cmd_done),
    .cmd_accept(acc), .cmd_refuse(rf), .command_lock(lock), .sequencer_ready_flag(rdy), .area_end_address(end_q),
    .valid_area_protect(prot), .irq(irq)
  );

  task automatic results();
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      err_count++;
      $display("unexpected at %0t: got %h, want %h", $time, g, x);
    end
  endtask

  // Handshakes are judged at the falling edge, where ready and valid are settled
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] m);
    logic ah, wh, bh;
    awaddr <= a;
    wdata <= v;
    wstrb <= m;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bh = 1'b0;
    for (int n = 0; n < 50 && !bh; n++) begin
      @(negedge clk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      r = bresp;
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
    if (!bh) begin
      err_count++;
      results();
    end
  endtask

  task automatic rd(input logic [7:0] a);
    logic h;
    araddr <= a;
    arvalid <= 1'b1;
    h = 1'b0;
    for (int n = 0; n < 50 && !h; n++) begin
      @(negedge clk);
      h = arvalid && arready;
      @(posedge clk);
      if (h) arvalid <= 1'b0;
    end
    h = 1'b0;
    for (int n = 0; n < 50 && !h; n++) begin
      @(negedge clk);
      h = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
    end
    if (!h) begin
      err_count++;
      results();
    end
  endtask

  // Accept and refuse stand for the one cycle after the take edge only
  task automatic cmd(input fre_cmd_e c, input logic va, input logic dm);
    kind <= c;
    cva <= va;
    dmap <= dm;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(negedge clk);
    ans = {acc, rf, lock};
    @(posedge clk);
  endtask

  task automatic fin();
    cmd_done <= 1'b1;
    @(posedge clk);
    cmd_done <= 1'b0;
    @(posedge clk);
    #1;
    chk({31'h0, rdy}, 32'h1);
  endtask

  function automatic logic bad(input fre_cmd_e c, input logic dn, input logic [31:0] a, input logic [31:0] z);
    if (a[20:16] != z[20:16]) return 1'b1;
    if (c == FRE_CMD_AREA_ERASE || !dn) return a[20:0] > z[20:0];
    return a[20:0] < z[20:0];
  endfunction

  initial begin
    void'($urandom(28));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(`FRE_OFF_END_ADDR);
    chk(d, `FRE_END_RESET);
    rd(`FRE_OFF_PROTECT);
    chk(d, 32'h00000001);
    rd(8'h3C);
    chk({30'h0, r}, {30'h0, `FRE_RESP_SLVERR});
    wr(8'h3C, 32'h0, 4'hF);
    chk({30'h0, r}, {30'h0, `FRE_RESP_SLVERR});
    wr(`FRE_OFF_IRQ_MASK, 32'h0, 4'hF);
    for (int i = 0; i < 24; i++) begin
      s = $urandom();
      e = $urandom();
      if (i % 2 == 0) e[20:16] = s[20:16];
      if (i < 4) e[20:0] = s[20:0];
      dir = 1'($urandom());
      k = (i % 4 < 2) ? FRE_CMD_AREA_ERASE : FRE_CMD_BLANK;
      b = bad(k, dir, s, e & `FRE_END_RO_MASK);
      wr(`FRE_OFF_START_ADDR, s, 4'hF);
      wr(`FRE_OFF_END_ADDR, e, 4'hF);
      wr(`FRE_OFF_CONTROL, {31'h0, dir}, 4'h1);
      rd(`FRE_OFF_END_ADDR);
      chk(d, e & `FRE_END_RO_MASK);
      cmd(k, 1'b0, 1'b0);
      chk({29'h0, ans}, {29'h0, !b, b, b});
      wr(`FRE_OFF_END_ADDR, ~e, 4'hF);
      wr(`FRE_OFF_PROTECT, 32'h0000FE00, 4'h3);
      rd(`FRE_OFF_END_ADDR);
      chk(d, (b ? ~e : e) & `FRE_END_RO_MASK);
      chk({31'h0, prot}, {31'h0, !b});
      if (b) begin
        wr(`FRE_OFF_CONTROL, 32'h2, 4'h1);
        #1;
        chk(end_q, `FRE_END_RESET);
        chk({30'h0, lock, prot}, 32'h1);
      end else begin
        fin();
      end
    end
    key = 8'($urandom());
    if (key == `FRE_PROT_KEY) key = 8'h00;
    wr(`FRE_OFF_PROTECT, {16'h0, key, 8'h00}, 4'h3);
    rd(`FRE_OFF_PROTECT);
    chk(d, 32'h1);
    wr(`FRE_OFF_PROTECT, 32'h0000FEFE, 4'h3);
    rd(`FRE_OFF_PROTECT);
    chk(d, 32'h0);
    cmd(FRE_CMD_CODE_WRITE, 1'b1, 1'b1);
    chk({29'h0, ans}, 32'h4);
    fin();
    wr(`FRE_OFF_PROTECT, 32'h0000FE01, 4'h3);
    cmd(FRE_CMD_CODE_WRITE, 1'b1, 1'b0);
    chk({29'h0, ans}, 32'h4);
    fin();
    cmd(FRE_CMD_CODE_WRITE, 1'b1, 1'b1);
    chk({28'h0, ans, irq}, 32'h4);
    wr(`FRE_OFF_IRQ_MASK, 32'h2, 4'hF);
    #1;
    chk({31'h0, irq}, 32'h1);
    rd(`FRE_OFF_IRQ_STATUS);
    chk(d & 32'h2, 32'h2);
    #1;
    chk({31'h0, irq}, 32'h0);
    results();
  end
endmodule
`default_nettype wire
